// ---- shared/sam_pkg.sv ----
/*
 * package for the shared channel 2 alarm / code violation / negative rail
 * input block: register map, field layout, reset values, role codes.
 * assumes a 32-bit ahb-lite slave port with byte addresses in haddr.
 */
package sam_pkg;

   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] SAM_OFS_CTRL = 8'h00;
   localparam logic [7:0] SAM_OFS_STS = 8'h04;
   localparam logic [7:0] SAM_OFS_MASK = 8'h08;
   localparam logic [7:0] SAM_OFS_CNT = 8'h0C;
   localparam logic [7:0] SAM_OFS_INFO = 8'h10;
   localparam int SAM_ADDR_W = 8;

   // ****************************************
   // field layout
   // ****************************************
   localparam int SAM_CTRL_TBUS = 0;
   localparam int SAM_CTRL_MODE_LSB = 1;
   localparam int SAM_CTRL_EDGE = 3;
   localparam int SAM_CTRL_W = 4;
   localparam int SAM_STS_AIS = 0;
   localparam int SAM_STS_LCV = 1;
   localparam int SAM_STS_W = 2;
   localparam int SAM_INFO_ROLE_LSB = 0;
   localparam int SAM_INFO_DATA_LSB = 8;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [3:0] SAM_CTRL_RST = 4'h0;
   localparam logic [1:0] SAM_STS_RST = 2'h0;
   localparam logic [1:0] SAM_MASK_RST = 2'h0;

   // ****************************************
   // channel modes and pin roles
   // ****************************************
   typedef enum logic [1:0] {
      SAM_MODE_STS1 = 2'b00,
      SAM_MODE_SINGLE = 2'b01,
      SAM_MODE_DUAL = 2'b10,
      SAM_MODE_RSVD = 2'b11
   } sam_mode_t;

   typedef enum logic [1:0] {
      SAM_ROLE_UNUSED = 2'b00,
      SAM_ROLE_LCV = 2'b01,
      SAM_ROLE_NEG = 2'b10,
      SAM_ROLE_ALARM = 2'b11
   } sam_role_t;

   localparam logic [1:0] SAM_HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] SAM_HSIZE_WORD = 3'b010;
   localparam logic SAM_HRESP_OKAY = 1'b0;
   localparam int SAM_SYNC_STAGES = 2;

endpackage

// ---- verilog/sam_sync.sv ----
/*
 * two flip-flop synchroniser for pins that arrive from outside hclk.
 * assumes each bit is independent; a multi-bit bus may show a mixed
 * word for one cycle, so callers sample buses only on a settled event.
 */
module sam_sync #(
   parameter int WIDTH = 1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // only the second stage reads the first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule

// ---- verilog/sam_top.sv ----
/*
 * shared channel 2 input: role selection, line clock edge sampling,
 * path ais declaration and code violation counting behind ahb-lite.
 * assumes pins are asynchronous to hclk and the line clock is well
 * below half the hclk rate so each of its edges is seen.
 */
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
// Function
// - telecom bus enabled makes the shared input the add-bus alarm
// - alarm rising edge while bus enabled declares the path ais defect
// - bus disabled: role follows channel mode sts1, single or dual rail
// - single rail: input is code violation, sampled on chosen clock edge
// - single rail: sampled violations increment the event counter
module sam_top #(
   parameter int CNT_W = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic shared_pin_in,
   input wire logic rx_line_clock,
   input wire logic [7:0] add_bus_data,
   output logic path_ais_declare,
   output logic lcv_event,
   output logic rx_negative_rail_out,
   output logic rx_negative_rail_valid,
   output logic irq
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic pin_s;
   logic lclk_s;
   logic [7:0] data_s;

   sam_sync #(.WIDTH(1)) u_pin (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in(shared_pin_in),
      .sync_out(pin_s)
   );
   sam_sync #(.WIDTH(1)) u_lclk (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in(rx_line_clock),
      .sync_out(lclk_s)
   );
   sam_sync #(.WIDTH(8)) u_data (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in(add_bus_data),
      .sync_out(data_s)
   );

   // ****************************************
   // registers
   // ****************************************
   logic [3:0] ctrl_ff;
   logic [1:0] sts_ff;
   logic [1:0] mask_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [7:0] ais_data_ff;
   logic pin_prev_ff;
   logic lclk_prev_ff;
   logic ais_ff;
   logic lcv_ff;
   logic neg_ff;
   logic neg_vld_ff;
   logic wr_pend_ff;
   logic [7:0] wr_addr_ff;
   logic [31:0] rdata_ff;

   // ****************************************
   // role selection
   // ****************************************
   wire tbus_en = ctrl_ff[sam_pkg::SAM_CTRL_TBUS];
   wire edge_fall = ctrl_ff[sam_pkg::SAM_CTRL_EDGE];
   wire sam_pkg::sam_mode_t mode =
      sam_pkg::sam_mode_t'(ctrl_ff[sam_pkg::SAM_CTRL_MODE_LSB +: 2]);
   wire sam_pkg::sam_role_t role =
      tbus_en ? sam_pkg::SAM_ROLE_ALARM :
      (mode == sam_pkg::SAM_MODE_SINGLE) ? sam_pkg::SAM_ROLE_LCV :
      (mode == sam_pkg::SAM_MODE_DUAL) ? sam_pkg::SAM_ROLE_NEG :
      sam_pkg::SAM_ROLE_UNUSED;

   // line clock edge chosen by software; a slow line clock is assumed
   wire lclk_rise = lclk_s & ~lclk_prev_ff;
   wire lclk_fall = ~lclk_s & lclk_prev_ff;
   wire lclk_edge = edge_fall ? lclk_fall : lclk_rise;
   wire alarm_rise = pin_s & ~pin_prev_ff;

   // unused role gates off all three event paths
   wire nxt_ais = (role == sam_pkg::SAM_ROLE_ALARM) & alarm_rise;
   wire nxt_lcv = (role == sam_pkg::SAM_ROLE_LCV) & lclk_edge & pin_s;
   wire nxt_neg_vld = (role == sam_pkg::SAM_ROLE_NEG) & lclk_edge;

   // ****************************************
   // ahb-lite slave, zero wait states
   // ****************************************
   wire [7:0] a_ofs = haddr[7:0];
   wire a_hit = (haddr[31:8] == 24'h000000);
   wire a_act = hsel & hready & htrans[1];
   wire a_rd = a_act & ~hwrite;
   wire a_wr = a_act & hwrite & a_hit;
   wire wr_go = wr_pend_ff & hready;
   wire wr_ctrl = wr_go & (wr_addr_ff == sam_pkg::SAM_OFS_CTRL);
   wire wr_sts = wr_go & (wr_addr_ff == sam_pkg::SAM_OFS_STS);
   wire wr_mask = wr_go & (wr_addr_ff == sam_pkg::SAM_OFS_MASK);
   wire wr_cnt = wr_go & (wr_addr_ff == sam_pkg::SAM_OFS_CNT);

   wire [31:0] info_word = {16'h0000, ais_data_ff, 6'h00, role};
   wire [31:0] rd_mux =
      !a_hit ? 32'h00000000 :
      (a_ofs == sam_pkg::SAM_OFS_CTRL) ? {28'h0000000, ctrl_ff} :
      (a_ofs == sam_pkg::SAM_OFS_STS) ? {30'h00000000, sts_ff} :
      (a_ofs == sam_pkg::SAM_OFS_MASK) ? {30'h00000000, mask_ff} :
      (a_ofs == sam_pkg::SAM_OFS_CNT) ? 32'(cnt_ff) :
      (a_ofs == sam_pkg::SAM_OFS_INFO) ? info_word : 32'h00000000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         rdata_ff <= 32'h00000000;
      end else begin
         if (hready) begin
            wr_pend_ff <= a_wr;
            wr_addr_ff <= a_ofs;
         end
         if (a_rd) begin
            rdata_ff <= rd_mux;
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = sam_pkg::SAM_HRESP_OKAY;
   assign hrdata = rdata_ff;

   // ****************************************
   // control, status, count
   // ****************************************
   wire [1:0] ev_vec = {lcv_ff, ais_ff};
   wire cnt_full = &cnt_ff;
   // set wins over the write-one clear in the same cycle
   wire [1:0] nxt_sts =
      (sts_ff & ~(wr_sts ? hwdata[sam_pkg::SAM_STS_W-1:0] : 2'b00)) | ev_vec;
   // counter saturates so software never sees a wrap as a low count
   wire [CNT_W-1:0] nxt_cnt =
      wr_cnt ? (lcv_ff ? CNT_W'(1) : '0) :
      (lcv_ff & ~cnt_full) ? cnt_ff + CNT_W'(1) : cnt_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= sam_pkg::SAM_CTRL_RST;
         sts_ff <= sam_pkg::SAM_STS_RST;
         mask_ff <= sam_pkg::SAM_MASK_RST;
         cnt_ff <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= hwdata[sam_pkg::SAM_CTRL_W-1:0];
         end
         if (wr_mask) begin
            mask_ff <= hwdata[sam_pkg::SAM_STS_W-1:0];
         end
         sts_ff <= nxt_sts;
         cnt_ff <= nxt_cnt;
      end
   end

   // ****************************************
   // event pipeline
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_prev_ff <= 1'b0;
         lclk_prev_ff <= 1'b0;
         ais_ff <= 1'b0;
         lcv_ff <= 1'b0;
         neg_ff <= 1'b0;
         neg_vld_ff <= 1'b0;
         ais_data_ff <= 8'h00;
      end else begin
         pin_prev_ff <= pin_s;
         lclk_prev_ff <= lclk_s;
         ais_ff <= nxt_ais;
         lcv_ff <= nxt_lcv;
         neg_vld_ff <= nxt_neg_vld;
         if (nxt_neg_vld) begin
            neg_ff <= pin_s;
         end
         if (nxt_ais) begin
            ais_data_ff <= data_s;
         end
      end
   end

   assign path_ais_declare = ais_ff;
   assign lcv_event = lcv_ff;
   assign rx_negative_rail_out = neg_ff;
   assign rx_negative_rail_valid = neg_vld_ff;
   assign irq = |(sts_ff & mask_ff);

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_ais_on_alarm: assert property (
      tbus_en && pin_s && !pin_prev_ff |=> path_ais_declare ##1 sts_ff[0])
      else $error("alarm rise did not declare path ais");
   a_ais_needs_bus: assert property (
      path_ais_declare |-> $past(tbus_en) && $past(pin_s))
      else $error("path ais declared without telecom bus");
   a_lcv_sampled: assert property (
      role == sam_pkg::SAM_ROLE_LCV && lclk_edge && pin_s |=> lcv_event)
      else $error("sampled violation not reported");
   a_lcv_edge_only: assert property (
      lcv_event |-> $past(lclk_edge) && $past(role == sam_pkg::SAM_ROLE_LCV))
      else $error("violation reported off the chosen edge");
   a_cnt_step: assert property (
      lcv_event && !cnt_full && !wr_cnt |=> cnt_ff == $past(cnt_ff) + 1'b1)
      else $error("violation count did not step");
   a_role_mode: assert property (
      !tbus_en && mode == sam_pkg::SAM_MODE_DUAL [*2] |-> !lcv_event)
      else $error("dual rail mode counted violations");
   a_neg_dual: assert property (
      rx_negative_rail_valid |-> $past(role == sam_pkg::SAM_ROLE_NEG))
      else $error("negative rail outside dual rail role");
   a_unused_quiet: assert property (
      role == sam_pkg::SAM_ROLE_UNUSED [*2] |->
         !lcv_event && !path_ais_declare && !rx_negative_rail_valid)
      else $error("unused role produced an event");
   a_irq_follow: assert property (
      sts_ff[0] && mask_ff[0] |-> irq)
      else $error("masked-in status without interrupt");
   a_ais_sticky: assert property (
      path_ais_declare |=> sts_ff[sam_pkg::SAM_STS_AIS])
      else $error("path ais status not set or lost to a clear");
   a_sts_clear: assert property (
      wr_sts && hwdata[sam_pkg::SAM_STS_AIS] && !ais_ff
         |=> !sts_ff[sam_pkg::SAM_STS_AIS])
      else $error("write one did not clear path ais status");
   a_cnt_hold: assert property (
      !lcv_event && !wr_cnt |=> $stable(cnt_ff))
      else $error("violation count moved without an event");

   c_ais: cover property (path_ais_declare ##1 irq);
   c_lcv: cover property (lcv_event ##[1:50] lcv_event);
   c_neg: cover property (rx_negative_rail_valid && rx_negative_rail_out);
   c_w1c: cover property (wr_sts && lcv_ff);

endmodule

// ---- verification/sam_liu_model.sv ----
/*
 * partner model: liu and add-bus source driving the shared pin.
 * assumes the bench calls its tasks; every change follows hclk.
 */
module sam_liu_model (
   input wire logic hclk,
   output logic pin,
   output logic lclk,
   output logic [7:0] data
);
   timeunit 1ns;
   timeprecision 1ps;
   int ones;
   logic last;
   // set by the bench in sts1 mode: the board keeps the pin low there
   logic hold_low;
   initial begin
      hold_low = 1'b0;
      pin = 1'b0;
      lclk = 1'b0;
      data = 8'h00;
      last = 1'b0;
   end
   // ****************************************
   // stimulus tasks
   // ****************************************
   // pin rests low first so a stale high cannot look like an alarm
   task automatic alarm(input logic [7:0] b);
      pin <= 1'b0;
      repeat (4) @(posedge hclk);
      pin <= ~hold_low;
      data <= b;
      @(posedge hclk);
      pin <= 1'b0;
      repeat (6) @(posedge hclk);
      data <= ~b;
   endtask
   // bit set half a line clock before the chosen edge, held past it
   task automatic frame(input int n, input logic fall);
      logic b;
      ones = 0;
      repeat (n) begin
         b = 1'($urandom);
         @(posedge hclk);
         lclk <= fall;
         pin <= b & ~hold_low;
         repeat (4) @(posedge hclk);
         lclk <= ~fall;
         repeat (4) @(posedge hclk);
         ones += int'(b);
         last = b;
      end
      // clock stands still; released pin shows the inverse
      lclk <= 1'b0;
      pin <= ~last & ~hold_low;
   endtask
endmodule

// ---- verification/sam_top_bench.sv ----
/*
 * bench for sam_top: ahb-lite master, pin partner, pulse counters.
 * assumes the partner owns the pin, line clock and add bus.
 */
module sam_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(n, e, g) begin \
   compares++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("BAD %s exp %h got %h", n, e, g); \
   end \
end
   logic hclk, hresetn, hsel, hwrite, pin, lclk, b1;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] data, b;
   logic hreadyout, hresp, ais, lcv, neg, negv, irq;
   int failures, compares, n_ais, n_lcv, n_neg, seed, k;
   sam_top i_sam_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .shared_pin_in(pin),
      .rx_line_clock(lclk), .add_bus_data(data),
      .path_ais_declare(ais), .lcv_event(lcv),
      .rx_negative_rail_out(neg), .rx_negative_rail_valid(negv),
      .irq(irq));
   sam_liu_model i_sam_liu_model (.hclk(hclk), .pin(pin), .lclk(lclk),
      .data(data));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      if (ais === 1'b1) n_ais++;
      if (lcv === 1'b1) n_lcv++;
      if (negv === 1'b1) n_neg++;
   end
   // ****************************************
   // bus tasks and verdict
   // ****************************************
   task automatic results();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic rdy();
      for (k = 0; k < 20; k++) begin
         @(posedge hclk);
         if (hreadyout === 1'b1) break;
      end
      if (k == 20) begin
         failures++;
         results();
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= sam_pkg::SAM_HTRANS_NONSEQ;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      rdy();
      rd = hrdata;
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {hresetn, hsel, hwrite} = 3'h0;
      {haddr, hwdata, htrans} = '0;
      hsize = sam_pkg::SAM_HSIZE_WORD;
      {failures, compares, n_ais, n_lcv, n_neg} = '0;
      seed = $urandom(32'h7ED86113);
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // reset values; offset 0x14 is unmapped and keeps no write
      bus(1'b1, 8'h14, 32'hFFFFFFFF);
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, 8'(i * 4), 32'h0);
         `CHK("reset", 32'h0, rd)
      end
      `CHK("hresp", 1'b0, hresp)
      // sts1 and reserved modes ignore line bits and alarms alike
      for (int m = 0; m < 8; m += 6) begin
         bus(1'b1, sam_pkg::SAM_OFS_CTRL, 32'(m));
         i_sam_liu_model.hold_low = (m == 0);
         i_sam_liu_model.frame(6, 1'b0);
         i_sam_liu_model.alarm(8'hA5);
         repeat (8) @(posedge hclk);
         `CHK("unused", 0, n_ais + n_lcv + n_neg)
         bus(1'b0, sam_pkg::SAM_OFS_STS, 32'h0);
         `CHK("unused sts", 32'h0, rd)
      end
      // single rail on both edges: events, count, status and irq
      for (int e = 0; e < 2; e++) begin
         bus(1'b1, sam_pkg::SAM_OFS_CNT, 32'h0);
         bus(1'b1, sam_pkg::SAM_OFS_CTRL, 32'(2 + 8 * e));
         n_lcv = 0;
         i_sam_liu_model.frame(8, 1'(e));
         repeat (8) @(posedge hclk);
         `CHK("lcv", i_sam_liu_model.ones, n_lcv)
         bus(1'b0, sam_pkg::SAM_OFS_CNT, 32'h0);
         `CHK("cnt", 32'(i_sam_liu_model.ones), rd)
         bus(1'b0, sam_pkg::SAM_OFS_INFO, 32'h0);
         `CHK("role", 32'h1, rd)
         b1 = (i_sam_liu_model.ones != 0);
         bus(1'b1, sam_pkg::SAM_OFS_MASK, 32'h2);
         @(negedge hclk);
         `CHK("irq", b1, irq)
         bus(1'b1, sam_pkg::SAM_OFS_STS, 32'h3);
         @(negedge hclk);
         `CHK("irq clr", 1'b0, irq)
      end
      // dual rail: one bit per chosen edge, never counted
      bus(1'b1, sam_pkg::SAM_OFS_CTRL, 32'h4);
      {n_neg, n_lcv} = '0;
      i_sam_liu_model.frame(7, 1'b0);
      repeat (8) @(posedge hclk);
      `CHK("neg n", 7, n_neg)
      `CHK("neg bit", i_sam_liu_model.last, neg)
      `CHK("neg lcv", 0, n_lcv)
      bus(1'b0, sam_pkg::SAM_OFS_INFO, 32'h0);
      `CHK("role", 32'h2, rd)
      // bus enable wins over single rail mode
      bus(1'b1, sam_pkg::SAM_OFS_CTRL, 32'h3);
      bus(1'b1, sam_pkg::SAM_OFS_MASK, 32'h1);
      n_ais = 0;
      b = 8'($urandom);
      i_sam_liu_model.alarm(b);
      repeat (8) @(posedge hclk);
      `CHK("ais n", 1, n_ais)
      `CHK("irq ais", 1'b1, irq)
      bus(1'b0, sam_pkg::SAM_OFS_INFO, 32'h0);
      `CHK("info", {16'h0000, b, 8'h03}, rd)
      bus(1'b0, sam_pkg::SAM_OFS_STS, 32'h0);
      `CHK("sts ais", 32'h1, rd)
      bus(1'b1, sam_pkg::SAM_OFS_MASK, 32'h0);
      @(negedge hclk);
      `CHK("irq mask", 1'b0, irq)
      results();
   end
endmodule
